// File: src/sam_pkg.sv
// Constants and types shared by the signed add, subtract and multiply unit
package sam_pkg;

  // ==========================================================================
  // Operation codes and widths
  typedef enum logic [1:0] {
    SAM_OP_ADD,
    SAM_OP_SUB,
    SAM_OP_MUL,
    SAM_OP_NONE
  } sam_op_e;

  localparam int unsigned WORD_W  = 16;
  localparam int unsigned DWORD_W = 32;
  localparam int unsigned QWORD_W = 64;
  localparam int unsigned TRUE_W  = 34;

  // ==========================================================================
  // Signed limits of the two operation widths
  localparam logic signed [TRUE_W-1:0] MIN16 = -34'sh0_0000_8000;
  localparam logic signed [TRUE_W-1:0] MAX16 = 34'sh0_0000_7FFF;
  localparam logic signed [TRUE_W-1:0] MIN32 = -34'sh0_8000_0000;
  localparam logic signed [TRUE_W-1:0] MAX32 = 34'sh0_7FFF_FFFF;

  // ==========================================================================
  // Program step counts of the two encodings
  localparam logic [3:0] STEPS_16 = 4'h7;
  localparam logic [3:0] STEPS_32 = 4'hD;

  // ==========================================================================
  // Nibble group limits for grouped bit destinations
  localparam logic [3:0] NIB_MAX16 = 4'h4;
  localparam logic [3:0] NIB_MAX32 = 4'h8;
  localparam int unsigned NIB_W    = 4;

  // ==========================================================================
  // Register port map (byte addresses) and reset values
  localparam logic [3:0]  REG_CTRL    = 4'h0;
  localparam logic [3:0]  REG_FLAGS   = 4'h4;
  localparam logic [3:0]  REG_STEPS   = 4'h8;
  localparam logic [3:0]  REG_COUNT   = 4'hC;
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned FLG_ZERO    = 0;
  localparam int unsigned FLG_BORROW  = 1;
  localparam int unsigned FLG_CARRY   = 2;
  localparam int unsigned FLG_REFUSE  = 3;
  localparam logic        CTRL_EN_RST = 1'b1;
  localparam logic [31:0] ZERO32      = 32'h0000_0000;

endpackage

// File: src/sam_unit.sv
// Signed add, subtract and multiply unit with its register port
// ============================================================================
// Summary of operation
// - Add writes two's-complement sum to destination
// - Subtract writes first minus second source
// - Operands are signed, arithmetic is algebraic
// - Add/sub with second index: 16-bit only
// - Zero result sets the zero flag
// - 16-bit result below minimum sets borrow
// - 16-bit result above maximum sets carry
// - 32-bit result below minimum sets borrow
// - 32-bit result above maximum sets carry
// - Subtract flags follow the add conditions
// - 32-bit operand: low word first, high next
// - 16-bit multiply gives 32-bit signed product
// - 32-bit multiply gives 64-bit signed product
// - Product bit 63 carries the result sign
// - Multiply source with second index: 16-bit only
// - Multiply destination with first index: 16-bit only
// - 16-bit multiply group holds one to four nibbles
// - 32-bit multiply group holds one to eight nibbles
// - Encoding is 13 steps wide, 7 narrow
// - Level mode every cycle, pulse mode per edge
//
// Our own choices: the plain strobed port and the placing of the registers.
module sam_unit (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire logic              exec_cond,
  input  wire logic              pulse_mode,
  input  wire sam_pkg::sam_op_e  op,
  input  wire logic              dword,
  input  wire logic              src_idx2,
  input  wire logic              dst_idx1,
  input  wire logic              dst_group,
  input  wire logic [3:0]        nibble_group_count,
  input  wire logic [15:0]       s1_lo,
  input  wire logic [15:0]       s1_hi,
  input  wire logic [15:0]       s2_lo,
  input  wire logic [15:0]       s2_hi,
  output logic [15:0]            dst_w0,
  output logic [15:0]            dst_w1,
  output logic [15:0]            dst_w2,
  output logic [15:0]            dst_w3,
  output logic                   dst_valid,
  output logic                   refused,
  output logic                   zero_result_flag,
  output logic                   underflow_borrow_flag,
  output logic                   overflow_carry_flag,
  output logic [3:0]             step_count,
  input  wire logic [3:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [31:0]            reg_rdata
);

  // ==========================================================================
  // Helpers
  function automatic logic [63:0] nib_mask(input logic [3:0] n, input logic [3:0] lim);
    logic [3:0] k;
    k = (n > lim) ? lim : n;
    nib_mask = (64'h1 << (k * 4)) - 64'h1;
  endfunction

  function automatic logic signed [sam_pkg::TRUE_W-1:0] widen(input logic [15:0] lo,
                                                              input logic [15:0] hi,
                                                              input logic        dw);
    // Narrow form only looks at the named word, sign extended
    if (dw) begin
      widen = {{2{hi[15]}}, hi, lo};
    end else begin
      widen = {{18{lo[15]}}, lo};
    end
  endfunction

  // ==========================================================================
  // State
  logic        cond_q, cond_d;
  logic        ctrl_en_q, ctrl_en_d;
  logic [15:0] w0_q, w0_d, w1_q, w1_d, w2_q, w2_d, w3_q, w3_d;
  logic        valid_q, valid_d, refused_q, refused_d;
  logic        zf_q, zf_d, bf_q, bf_d, cf_q, cf_d;
  logic [3:0]  steps_q, steps_d;
  logic [31:0] count_q, count_d;
  logic [31:0] rdata_q, rdata_d;

  logic                               fire;
  logic                               bad_form;
  logic signed [sam_pkg::TRUE_W-1:0]  a_w, b_w, true_res;
  logic signed [31:0]                 prod16;
  logic signed [63:0]                 prod32;
  logic [63:0]                        prod_sel;
  logic                               flag_zero, flag_borrow, flag_carry;

  // ==========================================================================
  // Execution trigger
  always_comb begin
    // Pulse mode acts once per rising edge of the condition
    if (pulse_mode) begin
      fire = exec_cond && !cond_q;
    end else begin
      fire = exec_cond;
    end
    fire = fire && ctrl_en_q && (op != sam_pkg::SAM_OP_NONE);
    cond_d = exec_cond;
  end

  // Wide forms are refused with the second source index; wide multiply also with the first destination index
  always_comb begin
    bad_form = 1'b0;
    if (dword) begin
      if (op == sam_pkg::SAM_OP_MUL) begin
        bad_form = src_idx2 || dst_idx1;
      end else begin
        bad_form = src_idx2;
      end
    end
  end

  // ==========================================================================
  // Datapath
  always_comb begin
    a_w = widen(s1_lo, s1_hi, dword);
    b_w = widen(s2_lo, s2_hi, dword);
    if (op == sam_pkg::SAM_OP_SUB) begin
      true_res = a_w - b_w;
    end else begin
      true_res = a_w + b_w;
    end
    prod16 = $signed(s1_lo) * $signed(s2_lo);
    prod32 = $signed({s1_hi, s1_lo}) * $signed({s2_hi, s2_lo});
    if (dword) begin
      prod_sel = prod32;
    end else begin
      prod_sel = {{32{prod16[31]}}, prod16};
    end
    // A grouped destination keeps only the low part that its nibbles cover
    if (dst_group) begin
      if (dword) begin
        prod_sel = prod_sel & nib_mask(nibble_group_count, sam_pkg::NIB_MAX32);
      end else begin
        prod_sel = prod_sel & nib_mask(nibble_group_count, sam_pkg::NIB_MAX16);
      end
    end
  end

  // Same conditions for add and subtract
  always_comb begin
    if (dword) begin
      flag_zero   = (true_res[31:0] == 32'h0000_0000);
      flag_borrow = (true_res < sam_pkg::MIN32);
      flag_carry  = (true_res > sam_pkg::MAX32);
    end else begin
      flag_zero   = (true_res[15:0] == 16'h0000);
      flag_borrow = (true_res < sam_pkg::MIN16);
      flag_carry  = (true_res > sam_pkg::MAX16);
    end
  end

  // ==========================================================================
  // Result and flag registers
  always_comb begin
    w0_d      = w0_q;
    w1_d      = w1_q;
    w2_d      = w2_q;
    w3_d      = w3_q;
    zf_d      = zf_q;
    bf_d      = bf_q;
    cf_d      = cf_q;
    steps_d   = steps_q;
    count_d   = count_q;
    valid_d   = 1'b0;
    refused_d = 1'b0;
    if (fire && bad_form) begin
      refused_d = 1'b1;
    end else if (fire) begin
      valid_d = 1'b1;
      steps_d = dword ? sam_pkg::STEPS_32 : sam_pkg::STEPS_16;
      count_d = count_q + 32'h0000_0001;
      if (op == sam_pkg::SAM_OP_MUL) begin
        // Multiply leaves the arithmetic flags alone
        w0_d = prod_sel[15:0];
        w1_d = prod_sel[31:16];
        w2_d = prod_sel[47:32];
        w3_d = prod_sel[63:48];
      end else begin
        // Wrap to the width, upper words untouched
        w0_d = true_res[15:0];
        if (dword) begin
          w1_d = true_res[31:16];
        end
        zf_d = flag_zero;
        bf_d = flag_borrow;
        cf_d = flag_carry;
      end
    end
  end

  // ==========================================================================
  // Register port
  always_comb begin
    ctrl_en_d = ctrl_en_q;
    rdata_d   = sam_pkg::ZERO32;
    if (reg_wr && (reg_addr == sam_pkg::REG_CTRL)) begin
      ctrl_en_d = reg_wdata[sam_pkg::CTRL_EN_BIT];
    end
    if (reg_rd) begin
      if (reg_addr == sam_pkg::REG_CTRL) begin
        rdata_d[sam_pkg::CTRL_EN_BIT] = ctrl_en_q;
      end else if (reg_addr == sam_pkg::REG_FLAGS) begin
        rdata_d[sam_pkg::FLG_ZERO]   = zf_q;
        rdata_d[sam_pkg::FLG_BORROW] = bf_q;
        rdata_d[sam_pkg::FLG_CARRY]  = cf_q;
        rdata_d[sam_pkg::FLG_REFUSE] = refused_q;
      end else if (reg_addr == sam_pkg::REG_STEPS) begin
        rdata_d[3:0] = steps_q;
      end else if (reg_addr == sam_pkg::REG_COUNT) begin
        rdata_d = count_q;
      end else begin
        rdata_d = sam_pkg::ZERO32;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cond_q    <= 1'b0;
      ctrl_en_q <= sam_pkg::CTRL_EN_RST;
      w0_q      <= 16'h0000;
      w1_q      <= 16'h0000;
      w2_q      <= 16'h0000;
      w3_q      <= 16'h0000;
      valid_q   <= 1'b0;
      refused_q <= 1'b0;
      zf_q      <= 1'b0;
      bf_q      <= 1'b0;
      cf_q      <= 1'b0;
      steps_q   <= 4'h0;
      count_q   <= sam_pkg::ZERO32;
      rdata_q   <= sam_pkg::ZERO32;
    end else if (ce) begin
      cond_q    <= cond_d;
      ctrl_en_q <= ctrl_en_d;
      w0_q      <= w0_d;
      w1_q      <= w1_d;
      w2_q      <= w2_d;
      w3_q      <= w3_d;
      valid_q   <= valid_d;
      refused_q <= refused_d;
      zf_q      <= zf_d;
      bf_q      <= bf_d;
      cf_q      <= cf_d;
      steps_q   <= steps_d;
      count_q   <= count_d;
      rdata_q   <= rdata_d;
    end
  end

  assign dst_w0                = w0_q;
  assign dst_w1                = w1_q;
  assign dst_w2                = w2_q;
  assign dst_w3                = w3_q;
  assign dst_valid             = valid_q;
  assign refused               = refused_q;
  assign zero_result_flag      = zf_q;
  assign underflow_borrow_flag = bf_q;
  assign overflow_carry_flag   = cf_q;
  assign step_count            = steps_q;
  assign reg_rdata             = rdata_q;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  logic add_go, sub_go, mul_go;
  assign add_go = ce && fire && !bad_form && (op == sam_pkg::SAM_OP_ADD);
  assign sub_go = ce && fire && !bad_form && (op == sam_pkg::SAM_OP_SUB);
  assign mul_go = ce && fire && !bad_form && (op == sam_pkg::SAM_OP_MUL);

  add_result_a: assert property (add_go && !dword |=>
      dst_w0 == $past(s1_lo) + $past(s2_lo))
    else $error("narrow add result wrong");

  sub_result_a: assert property (sub_go && dword |=>
      {dst_w1, dst_w0} == {$past(s1_hi), $past(s1_lo)} - {$past(s2_hi), $past(s2_lo)})
    else $error("wide subtract result wrong");

  wide_refuse_a: assert property (ce && fire && dword && src_idx2 |=>
      refused && !dst_valid && $stable(dst_w0))
    else $error("wide form with index not refused");

  zero_flag_a: assert property (add_go && !dword && (s1_lo + s2_lo == 16'h0000) |=>
      zero_result_flag)
    else $error("zero flag missing");

  // Overflow judged from operand and result signs, independent of the wide adder
  borrow16_a: assert property ((add_go || sub_go) && !dword |=>
      underflow_borrow_flag == ($past(s1_lo[15]) && !dst_w0[15]
        && ($past(sub_go) ? !$past(s2_lo[15]) : $past(s2_lo[15]))))
    else $error("narrow borrow flag wrong");

  carry16_a: assert property ((add_go || sub_go) && !dword |=>
      overflow_carry_flag == (!$past(s1_lo[15]) && dst_w0[15]
        && ($past(sub_go) ? $past(s2_lo[15]) : !$past(s2_lo[15]))))
    else $error("narrow carry flag wrong");

  borrow32_a: assert property ((add_go || sub_go) && dword |=>
      underflow_borrow_flag == ($past(s1_hi[15]) && !dst_w1[15]
        && ($past(sub_go) ? !$past(s2_hi[15]) : $past(s2_hi[15]))))
    else $error("wide borrow flag wrong");

  carry32_a: assert property ((add_go || sub_go) && dword |=>
      overflow_carry_flag == (!$past(s1_hi[15]) && dst_w1[15]
        && ($past(sub_go) ? $past(s2_hi[15]) : !$past(s2_hi[15]))))
    else $error("wide carry flag wrong");

  mul16_sign_a: assert property (mul_go && !dword && !dst_group |=>
      dst_w1[15] == ($past(s1_lo[15]) ^ $past(s2_lo[15])) || {dst_w1, dst_w0} == 32'h0)
    else $error("narrow product sign wrong");

  mul_flags_a: assert property (mul_go |=>
      $stable(zero_result_flag) && $stable(overflow_carry_flag)
      && $stable(underflow_borrow_flag))
    else $error("multiply disturbed flags");

  mul32_prod_a: assert property (mul_go && dword && !dst_group |=>
      {dst_w3, dst_w2, dst_w1, dst_w0} ==
      $past(64'($signed({s1_hi, s1_lo})) * 64'($signed({s2_hi, s2_lo}))))
    else $error("wide product wrong");

  group16_a: assert property (mul_go && !dword && dst_group |=>
      {dst_w3, dst_w2, dst_w1} == 48'h0000_0000_0000)
    else $error("narrow group wider than sixteen bits");

  group32_a: assert property (mul_go && dword && dst_group |=>
      {dst_w3, dst_w2} == 32'h0000_0000)
    else $error("wide group wider than thirty-two bits");

  pulse_once_a: assert property (pulse_mode && ce && exec_cond && cond_q |=>
      !dst_valid && !refused)
    else $error("pulse mode fired without an edge");

  steps_a: assert property (add_go && dword |=> step_count == sam_pkg::STEPS_32)
    else $error("wide step count wrong");

  add_cov_c:   cover property (add_go ##1 dst_valid && overflow_carry_flag);
  mul32_cov_c: cover property (mul_go && dword);
  ref_cov_c:   cover property (refused);
  pulse_cov_c: cover property (pulse_mode && dst_valid);

endmodule

// File: verification/sam_seq_model.sv
// Sequencer and operand memory model that feeds the arithmetic unit
module sam_seq_model (
  input  wire logic        ref_clk,
  input  wire logic        show,
  input  wire logic [31:0] a_val,
  input  wire logic [31:0] b_val,
  output logic [15:0]      s1_lo,
  output logic [15:0]      s1_hi,
  output logic [15:0]      s2_lo,
  output logic [15:0]      s2_hi
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] junk_q = 32'h0000_0000;
  // Between executions the memory bus churns, so stale operands never look valid
  always @(posedge ref_clk) begin
    junk_q <= ~junk_q + 32'h0000_1357;
  end
  assign s1_lo = show ? a_val[15:0] : junk_q[15:0];
  assign s1_hi = show ? a_val[31:16] : ~junk_q[31:16];
  assign s2_lo = show ? b_val[15:0] : ~junk_q[15:0];
  assign s2_hi = show ? b_val[31:16] : junk_q[31:16];
endmodule

// File: verification/tb_top.sv
// Self-checking bench for the signed add, subtract and multiply unit
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic ce, exec_cond, pulse_mode, dword, src_idx2, dst_idx1, dst_group, show, reg_wr, reg_rd;
  logic dst_valid, refused, zero_result_flag, underflow_borrow_flag, overflow_carry_flag;
  logic ez, eb, ec;
  sam_pkg::sam_op_e op;
  logic [3:0]  nibble_group_count, step_count, reg_addr, es;
  logic [15:0] s1_lo, s1_hi, s2_lo, s2_hi, dst_w0, dst_w1, dst_w2, dst_w3, w0_keep;
  logic [31:0] a_val, b_val, reg_wdata, reg_rdata;
  int          miscompares = 0, total_checks = 0, cycles = 0, seed = 51, n, execs = 0;
  logic [31:0] ca [8] = '{32'h7FFF, 32'h8000, 32'h8000, 32'h1234,
                          32'h7FFF_FFFF, 32'h8000_0000, 32'h8000_0000, 32'hFFFF_FFFF};
  logic [31:0] cb [8] = '{32'h1, 32'h1, 32'h8000, 32'h1234,
                          32'h1, 32'h1, 32'h8000_0000, 32'hFFFF_FFFF};

  sam_unit dut_u (.ref_clk(ref_clk), .rst(rst), .ce(ce), .exec_cond(exec_cond),
    .pulse_mode(pulse_mode), .op(op), .dword(dword), .src_idx2(src_idx2), .dst_idx1(dst_idx1),
    .dst_group(dst_group), .nibble_group_count(nibble_group_count), .s1_lo(s1_lo),
    .s1_hi(s1_hi), .s2_lo(s2_lo), .s2_hi(s2_hi), .dst_w0(dst_w0), .dst_w1(dst_w1),
    .dst_w2(dst_w2), .dst_w3(dst_w3), .dst_valid(dst_valid), .refused(refused),
    .zero_result_flag(zero_result_flag), .underflow_borrow_flag(underflow_borrow_flag),
    .overflow_carry_flag(overflow_carry_flag), .step_count(step_count), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  sam_seq_model model_u (.ref_clk(ref_clk), .show(show), .a_val(a_val), .b_val(b_val),
    .s1_lo(s1_lo), .s1_hi(s1_hi), .s2_lo(s2_lo), .s2_hi(s2_hi));

  always #2 ref_clk = ~ref_clk;
  // Hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      report_and_stop();
    end
  end

  // ==========================================================================
  // Shared tasks
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic run(input sam_pkg::sam_op_e o, input logic dw, input logic [31:0] a, b);
    @(posedge ref_clk);
    op <= o;
    dword <= dw;
    a_val <= a;
    b_val <= b;
    show <= 1'b1;
    exec_cond <= 1'b1;
    @(posedge ref_clk);
    exec_cond <= 1'b0;
    show <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // ==========================================================================
  // Reference models
  task automatic addsub(input sam_pkg::sam_op_e o, input logic dw, input logic [31:0] a, b);
    longint sa, sb, t, lo, hi;
    sa = dw ? longint'($signed(a)) : longint'($signed(a[15:0]));
    sb = dw ? longint'($signed(b)) : longint'($signed(b[15:0]));
    t = (o == sam_pkg::SAM_OP_ADD) ? sa + sb : sa - sb;
    lo = dw ? -64'sh8000_0000 : -64'sh8000;
    hi = dw ? 64'sh7FFF_FFFF : 64'sh7FFF;
    ez = dw ? (t[31:0] == 32'h0) : (t[15:0] == 16'h0);
    eb = t < lo;
    ec = t > hi;
    es = dw ? 4'hD : 4'h7;
    run(o, dw, a, b);
    execs++;
    chk(dst_valid, 1'b1);
    chk(dst_w0, t[15:0]);
    if (dw) begin
      chk(dst_w1, t[31:16]);
    end
    chk({zero_result_flag, underflow_borrow_flag, overflow_carry_flag}, {ez, eb, ec});
    chk(step_count, es);
  endtask
  task automatic mul(input logic dw, input logic [31:0] a, b, input int k, input logic grp);
    longint p;
    logic [63:0] m;
    p = dw ? longint'($signed(a)) * longint'($signed(b))
           : longint'($signed(a[15:0])) * longint'($signed(b[15:0]));
    if (k > (dw ? 8 : 4)) begin
      k = dw ? 8 : 4;
    end
    m = (64'h1 << (4 * k)) - 64'h1;
    es = dw ? 4'hD : 4'h7;
    dst_group <= grp;
    nibble_group_count <= 4'(k);
    run(sam_pkg::SAM_OP_MUL, dw, a, b);
    execs++;
    chk(dst_valid, 1'b1);
    if (grp) begin
      chk({dst_w1, dst_w0}, p[31:0] & m[31:0]);
    end else begin
      chk({dst_w3, dst_w2, dst_w1, dst_w0}, p);
    end
  endtask
  task automatic refuse(input sam_pkg::sam_op_e o, input logic si, input logic di);
    logic [63:0] held;
    held = {dst_w3, dst_w2, dst_w1, dst_w0};
    src_idx2 <= si;
    dst_idx1 <= di;
    run(o, 1'b1, $random(seed), $random(seed));
    chk({refused, dst_valid}, 2'b10);
    chk({dst_w3, dst_w2, dst_w1, dst_w0}, held);
    src_idx2 <= 1'b0;
    dst_idx1 <= 1'b0;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    {ce, exec_cond, pulse_mode, dword, src_idx2, dst_idx1, dst_group, show} = 8'h80;
    {reg_wr, reg_rd, nibble_group_count, reg_addr} = 10'h000;
    op = sam_pkg::SAM_OP_NONE;
    {a_val, b_val, reg_wdata} = 96'h0;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    rd(sam_pkg::REG_CTRL, 32'h0000_0001);
    rd(sam_pkg::REG_COUNT, 32'h0000_0000);
    rd(4'h2, 32'h0000_0000);
    addsub(sam_pkg::SAM_OP_ADD, 1'b0, 32'h0000_0003, 32'h0000_FFF7);
    for (int i = 0; i < 8; i++) begin
      src_idx2 <= (i == 1);
      addsub(i[0] ? sam_pkg::SAM_OP_SUB : sam_pkg::SAM_OP_ADD, i[2], ca[i], cb[i]);
    end
    src_idx2 <= 1'b0;
    repeat (40) begin
      addsub(($random(seed) & 1) ? sam_pkg::SAM_OP_SUB : sam_pkg::SAM_OP_ADD,
             1'($random(seed)), $random(seed), $random(seed));
    end
    mul(1'b1, 32'h8000_0000, 32'h8000_0000, 0, 1'b0);
    mul(1'b0, 32'h0000_8000, 32'h0000_7FFF, 0, 1'b0);
    repeat (20) mul(1'($random(seed)), $random(seed), $random(seed), 0, 1'b0);
    for (int k = 0; k < 10; k++) begin
      mul(k[0], $random(seed), $random(seed), k, 1'b1);
    end
    dst_group <= 1'b0;
    w0_keep = dst_w0;
    // Multiply must leave the add and subtract flags as they were
    rd(sam_pkg::REG_FLAGS, {29'h0, ec, eb, ez});
    wr(sam_pkg::REG_STEPS, 32'hFFFF_FFFF);
    rd(sam_pkg::REG_STEPS, {28'h0, es});
    refuse(sam_pkg::SAM_OP_ADD, 1'b1, 1'b0);
    refuse(sam_pkg::SAM_OP_SUB, 1'b1, 1'b0);
    refuse(sam_pkg::SAM_OP_MUL, 1'b1, 1'b0);
    refuse(sam_pkg::SAM_OP_MUL, 1'b0, 1'b1);
    // Refused forms must not count as executions
    rd(sam_pkg::REG_COUNT, execs);
    wr(sam_pkg::REG_CTRL, 32'h0);
    run(sam_pkg::SAM_OP_ADD, 1'b0, 32'h1, 32'h1);
    chk(dst_valid, 1'b0);
    chk(dst_w0, w0_keep);
    wr(sam_pkg::REG_CTRL, 32'h1);
    // Clock enable low freezes the unit even with the condition held
    ce <= 1'b0;
    run(sam_pkg::SAM_OP_SUB, 1'b0, 32'h9, 32'h2);
    chk(dst_valid, 1'b0);
    chk(dst_w0, w0_keep);
    ce <= 1'b1;
    // Level mode acts at every held edge, pulse mode only at the first
    for (int pm = 0; pm < 2; pm++) begin
      @(posedge ref_clk);
      pulse_mode <= pm[0];
      show <= 1'b1;
      exec_cond <= 1'b1;
      n = 0;
      repeat (4) begin
        @(posedge ref_clk);
        #1;
        n = n + (dst_valid === 1'b1);
      end
      exec_cond <= 1'b0;
      chk(n, pm ? 1 : 4);
    end
    report_and_stop();
  end
endmodule
